// ---- verilog/wfs_supervisor.sv ----
// weld fault supervisor: qualifies fault pins, keeps error codes,
// gates weld output, drives buzzer and fan, AHB-Lite register slave
// assumes fault pins are asynchronous levels, active high, and that
// i_resetn is asserted at every power-up
`timescale 1ns/1ns
`default_nettype none
`include "wfs_consts.svh"

module wfs_supervisor
    import wfs_pkg::*;
#(
    parameter int TICK_CYCLES = `WFS_TICK_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_switch_heatsink_sensor_above80,
    input wire logic i_switch_heatsink_sensor_above70,
    input wire logic i_diode_heatsink_sensor_above80,
    input wire logic i_diode_heatsink_sensor_above70,
    input wire logic i_primary_overcurrent,
    input wire logic i_output_overvoltage,
    input wire logic i_cap_overvoltage,
    input wire logic i_cap_undervoltage,
    input wire logic i_supply_low,
    input wire logic i_supply_wrong,
    input wire logic i_link_plug_absent,
    input wire logic i_supply_unstable,
    input wire logic i_precharge_fail,
    input wire logic i_param_mem_fail,
    input wire logic i_switch_heatsink_sensor_open,
    input wire logic i_diode_heatsink_sensor_open,
    input wire logic i_mains_lost,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic o_weld_enable,
    output logic o_buzzer,
    output logic o_fan_max,
    output logic [7:0] o_err_code,
    output logic o_err_valid,
    output logic o_irq
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // display number of a code bit, two decimal digits
    function automatic logic [7:0] code_number(input logic [3:0] idx);
        case (idx)
            WFS_E01: code_number = 8'h01;
            WFS_E02: code_number = 8'h02;
            WFS_E03: code_number = 8'h03;
            WFS_E04: code_number = 8'h04;
            WFS_E11: code_number = 8'h11;
            WFS_E12: code_number = 8'h12;
            WFS_E14: code_number = 8'h14;
            WFS_E81: code_number = 8'h81;
            WFS_E82: code_number = 8'h82;
            WFS_E83: code_number = 8'h83;
            WFS_E85: code_number = 8'h85;
            WFS_E93: code_number = 8'h93;
            WFS_E94: code_number = 8'h94;
            WFS_E99: code_number = 8'h99;
            default: code_number = 8'h00;
        endcase
    endfunction

    // lowest set bit among a group, or 4'hF when none
    function automatic logic [3:0] first_set(input wfs_codes_t v);
        logic [3:0] r;
        r = 4'hF;
        for (int i = 13; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        first_set = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    localparam int NPIN = 17;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_meta_reg;
    logic [NPIN-1:0] pin_reg;

    assign pin_raw = {i_mains_lost, i_diode_heatsink_sensor_open,
        i_switch_heatsink_sensor_open, i_param_mem_fail, i_precharge_fail,
        i_supply_unstable, i_link_plug_absent, i_supply_wrong, i_supply_low,
        i_cap_undervoltage, i_cap_overvoltage, i_output_overvoltage,
        i_primary_overcurrent, i_diode_heatsink_sensor_above70,
        i_diode_heatsink_sensor_above80, i_switch_heatsink_sensor_above70,
        i_switch_heatsink_sensor_above80};

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            pin_meta_reg <= '0;
            pin_reg <= '0;
        end else begin
            pin_meta_reg <= pin_raw;
            pin_reg <= pin_meta_reg;
        end
    end

    logic sw_hot, sw_warm, dd_hot, dd_warm, over_cur, out_ov, cap_ov, cap_uv;
    logic sup_low, sup_wrong, link_abs, sup_unst, pre_fail, mem_fail;
    logic sens_open, mains_lost;
    assign {mains_lost, mem_fail, pre_fail, sup_unst, link_abs, sup_wrong, sup_low, cap_uv, cap_ov, out_ov,
        over_cur, dd_warm, dd_hot, sw_warm, sw_hot} = {pin_reg[16], pin_reg[13:0]};
    assign sens_open = pin_reg[14] | pin_reg[15];

    ////////////////////////////////////////////////////////////////////////
    // tick divider, one pulse per millisecond

    logic [15:0] div_reg;
    logic tick_reg;

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            div_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else if (div_reg == 16'(TICK_CYCLES - 1)) begin
            div_reg <= 16'h0000;
            tick_reg <= 1'b1; // RQ17
        end else begin
            div_reg <= div_reg + 16'h0001;
            tick_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // time qualifiers: set and recover windows

    localparam int NQ = 7;
    localparam wfs_count_t SET_T = 15'(`WFS_SET_TICKS);
    localparam wfs_count_t CLR_T = 15'(`WFS_CLR_TICKS);
    logic [NQ-1:0] q_cond;
    logic [NQ-1:0] q_hit;

    // 0 e01 set, 1 e01 recover, 2 e02 set, 3 e02 recover, 4 e11, 5 e12, 6 e14
    assign q_cond = {sup_low, cap_uv, cap_ov, !dd_warm, dd_hot, !sw_warm, sw_hot};

    wfs_qual_if qif[NQ] ();

    for (genvar g = 0; g < NQ; g++) begin : g_qual
        assign qif[g].tick = tick_reg;
        assign qif[g].cond = q_cond[g];
        assign q_hit[g] = qif[g].hit;
        wfs_qualifier #(
            .LIMIT((g == 1 || g == 3) ? CLR_T : SET_T)
        ) u_qual (
            .i_core_clk(i_core_clk),
            .i_resetn(i_resetn),
            .q(qif[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // power-up supply check window

    wfs_state_t state_reg;
    wfs_count_t start_cnt_reg;

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            state_reg <= WFS_ST_CHECK;
            start_cnt_reg <= 15'h0000;
        end else begin
            case (state_reg)
                WFS_ST_CHECK: begin
                    if (tick_reg) begin
                        start_cnt_reg <= start_cnt_reg + 15'h0001;
                    end
                    if (start_cnt_reg == 15'(`WFS_START_TICKS)) begin
                        state_reg <= WFS_ST_RUN;
                    end
                end
                WFS_ST_RUN: state_reg <= WFS_ST_RUN;
                default: state_reg <= WFS_ST_CHECK;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // code state

    wfs_codes_t act_reg;
    wfs_codes_t act_prev_reg;
    logic in_check;

    assign in_check = (state_reg == WFS_ST_CHECK);

    // one process owns the code vector: thermal codes set and recover, capacitor and
    // supply-low codes follow their qualified level, the rest latch until power-up reset
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            act_reg <= '0;
        end else begin
            if (q_hit[0]) begin
                act_reg[WFS_E01] <= 1'b1; // RQ1
            end else if (q_hit[1]) begin
                act_reg[WFS_E01] <= 1'b0; // RQ2
            end
            if (q_hit[2]) begin
                act_reg[WFS_E02] <= 1'b1; // RQ3
            end else if (q_hit[3]) begin
                act_reg[WFS_E02] <= 1'b0; // RQ4
            end
            act_reg[WFS_E11] <= q_hit[4]; // RQ7
            act_reg[WFS_E12] <= q_hit[5]; // RQ8
            act_reg[WFS_E14] <= q_hit[6]; // RQ9
            act_reg[WFS_E03] <= act_reg[WFS_E03] | over_cur; // RQ5
            act_reg[WFS_E04] <= act_reg[WFS_E04] | out_ov; // RQ6
            act_reg[WFS_E81] <= act_reg[WFS_E81] | (in_check & sup_wrong); // RQ10
            act_reg[WFS_E82] <= act_reg[WFS_E82] | link_abs; // RQ11
            act_reg[WFS_E83] <= act_reg[WFS_E83] | (in_check & sup_unst); // RQ12
            act_reg[WFS_E85] <= act_reg[WFS_E85] | pre_fail; // RQ13
            act_reg[WFS_E93] <= act_reg[WFS_E93] | mem_fail; // RQ14
            act_reg[WFS_E94] <= act_reg[WFS_E94] | sens_open; // RQ15
            act_reg[WFS_E99] <= act_reg[WFS_E99] | mains_lost; // RQ16
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            act_prev_reg <= '0;
        end else begin
            act_prev_reg <= act_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs to the power stage and the operator

    wfs_codes_t latched_m, auto_m, warn_m;
    logic shutdown;
    logic [3:0] shown;

    assign latched_m = act_reg & 14'h3F8C;
    assign auto_m = act_reg & 14'h0033;
    assign warn_m = act_reg & 14'h0040;
    assign shutdown = |(latched_m | auto_m);
    assign shown = (|latched_m) ? first_set(latched_m) :
        ((|auto_m) ? first_set(auto_m) : first_set(warn_m)); // RQ18

    logic [9:0] blink_cnt_reg;
    logic blink_reg;

    // intermittent buzzer: half-second on, half-second off
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn || !act_reg[WFS_E14]) begin
            blink_cnt_reg <= 10'h000;
            blink_reg <= 1'b1;
        end else if (tick_reg) begin
            if (blink_cnt_reg == 10'(`WFS_BLINK_TICKS - 1)) begin
                blink_cnt_reg <= 10'h000;
                blink_reg <= !blink_reg; // RQ9
            end else begin
                blink_cnt_reg <= blink_cnt_reg + 10'h001;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_weld_enable <= 1'b0;
            o_buzzer <= 1'b0;
            o_fan_max <= 1'b0;
            o_err_code <= 8'h00;
            o_err_valid <= 1'b0;
        end else begin
            // weld held off during the power-up supply check
            o_weld_enable <= !shutdown && !in_check; // RQ18 RQ10 RQ12
            o_buzzer <= shutdown | (act_reg[WFS_E14] & blink_reg); // RQ1 RQ9
            o_fan_max <= act_reg[WFS_E01] | act_reg[WFS_E02]; // RQ1 RQ3
            o_err_code <= code_number(shown); // RQ18
            o_err_valid <= |act_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states

    wfs_codes_t status_reg, status_next, mask_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic acc;
    logic [7:0] a_ofs;
    logic [31:0] rd_mux;

    assign acc = i_hsel && i_htrans[1] && i_hready;
    assign a_ofs = i_haddr[7:0];

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (i_haddr[31:8] == 24'h000000) begin
            case (a_ofs)
                `WFS_OFS_ACTIVE: rd_mux = {18'h00000, act_reg};
                `WFS_OFS_STATUS: rd_mux = {18'h00000, status_reg};
                `WFS_OFS_MASK: rd_mux = {18'h00000, mask_reg};
                `WFS_OFS_DISPLAY: rd_mux = {19'h00000, !in_check, o_fan_max,
                    o_buzzer, o_weld_enable, o_err_valid, o_err_code};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            o_hrdata <= 32'h0000_0000;
            o_hreadyout <= 1'b0;
            o_hresp <= 1'b0;
        end else begin
            wr_pend_reg <= acc && i_hwrite && (i_haddr[31:8] == 24'h000000);
            wr_addr_reg <= a_ofs;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            if (acc && !i_hwrite) begin
                o_hrdata <= rd_mux;
            end
        end
    end

    // a new event wins over a write-one-to-clear in the same cycle
    always_comb begin
        status_next = status_reg;
        if (wr_pend_reg && wr_addr_reg == `WFS_OFS_STATUS) begin
            status_next = status_next & ~i_hwdata[13:0];
        end
        status_next = status_next | (act_reg & ~act_prev_reg);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            status_reg <= `WFS_STATUS_RST;
        end else begin
            status_reg <= status_next;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            mask_reg <= `WFS_MASK_RST;
        end else if (wr_pend_reg && wr_addr_reg == `WFS_OFS_MASK) begin
            mask_reg <= i_hwdata[13:0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(status_next & mask_reg);
        end
    end

endmodule

`default_nettype wire

// ---- verilog/wfs_consts.svh ----
// constants of the weld fault supervisor: offsets, reset values, timing
// assumes a 50 MHz core clock and a 1 ms qualification tick
// Function
// RQ1: switch heatsink above 80C for 1 s: show E01, stop weld, buzzer, fan max.
// RQ2: E01 clears after switch heatsink at or below 70C for 30 s.
// RQ3: diode heatsink above 80C for 1 s: show E02, stop weld, buzzer, fan max.
// RQ4: E02 clears after diode heatsink at or below 70C for 30 s.
// RQ5: primary overcurrent: E03, stop weld, buzzer, latched until power cycle.
// RQ6: output overvoltage: E04, stop weld, buzzer, latched until power cycle.
// RQ7: capacitor overvoltage for 1 s: E11, stop weld, buzzer, auto clears.
// RQ8: dangerous capacitor undervoltage for 1 s: E12, stop weld, buzzer, auto clears.
// RQ9: supply 10% low for 1 s: warning E14, weld allowed, intermittent buzzer.
// RQ10: wrong supply at first power-up: E81, weld never enabled, buzzer.
// RQ11: link selection plug absent: E82, weld disabled, buzzer until power off.
// RQ12: unstable supply at switch-on: E83, weld disabled, buzzer, latched.
// RQ13: precharge failure: E85, weld disabled, buzzer, only power cycle clears.
// RQ14: parameter memory failure: E93, stop weld, buzzer until power off.
// RQ15: either temperature sensor open: E94, stop weld, buzzer until power off.
// RQ16: mains lost on capacitor power: E99, stop weld, buzzer, power cycle clears.
// RQ17: time qualification counts fixed ticks and restarts when condition lapses.
// RQ18: display by priority latched, auto, warning; weld blocked on any shutdown.
`ifndef WFS_CONSTS_SVH
`define WFS_CONSTS_SVH

`define WFS_CLK_NS 20
`define WFS_TICK_NS 1000000
`define WFS_TICK_CYCLES (`WFS_TICK_NS / `WFS_CLK_NS)
// counts in 1 ms ticks; plain numbers avoid 32-bit overflow in products
`define WFS_SET_TICKS 1000
`define WFS_CLR_TICKS 30000
`define WFS_BLINK_TICKS 500
`define WFS_START_TICKS 1000

`define WFS_OFS_ACTIVE 8'h00
`define WFS_OFS_STATUS 8'h04
`define WFS_OFS_MASK 8'h08
`define WFS_OFS_DISPLAY 8'h0C

`define WFS_MASK_RST 14'h0000
`define WFS_STATUS_RST 14'h0000

`define WFS_DISP_CODE_LSB 0
`define WFS_DISP_VALID_BIT 8
`define WFS_DISP_WELD_BIT 9
`define WFS_DISP_BUZZ_BIT 10
`define WFS_DISP_FAN_BIT 11
`define WFS_DISP_RUN_BIT 12

`endif

// ---- verilog/wfs_pkg.sv ----
// types shared by the weld fault supervisor modules
// assumes nothing beyond the constants header
`default_nettype none
package wfs_pkg;

    // bit positions of the code vector
    typedef enum logic [3:0] {
        WFS_E01 = 4'h0, WFS_E02 = 4'h1, WFS_E03 = 4'h2, WFS_E04 = 4'h3,
        WFS_E11 = 4'h4, WFS_E12 = 4'h5, WFS_E14 = 4'h6, WFS_E81 = 4'h7,
        WFS_E82 = 4'h8, WFS_E83 = 4'h9, WFS_E85 = 4'hA, WFS_E93 = 4'hB,
        WFS_E94 = 4'hC, WFS_E99 = 4'hD
    } wfs_code_t;

    typedef logic [13:0] wfs_codes_t;

    // gray along check -> run
    typedef enum logic [1:0] {
        WFS_ST_CHECK = 2'b00,
        WFS_ST_RUN = 2'b01
    } wfs_state_t;

    typedef logic [14:0] wfs_count_t;

endpackage
`default_nettype wire

// ---- verilog/wfs_qual_if.sv ----
// carrier between the supervisor and its time qualifiers
// assumes tick and cond come from the core clock domain
`timescale 1ns/1ns
`default_nettype none

interface wfs_qual_if;
    logic tick;
    logic cond;
    logic hit;
    modport qual(input tick, input cond, output hit);
    modport user(output tick, output cond, input hit);
endinterface

`default_nettype wire

// ---- verilog/wfs_qualifier.sv ----
// time qualifier: hit rises once cond has held for LIMIT ticks
// assumes a one-cycle tick enable on the core clock
`timescale 1ns/1ns
`default_nettype none

module wfs_qualifier
    import wfs_pkg::*;
#(
    parameter wfs_count_t LIMIT = 15'h03E8
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    wfs_qual_if.qual q
);

    wfs_count_t cnt_reg;
    logic hit_reg;

    // a lapse of the condition throws away the time already counted
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn || !q.cond) begin
            cnt_reg <= 15'h0000; // RQ17
        end else if (q.tick && cnt_reg != LIMIT) begin
            cnt_reg <= cnt_reg + 15'h0001; // RQ17
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            hit_reg <= 1'b0;
        end else begin
            hit_reg <= q.cond && (cnt_reg == LIMIT);
        end
    end

    assign q.hit = hit_reg;

endmodule

`default_nettype wire

// ---- verification/wfs_supervisor_asserts.sv ----
// port-level checker for the weld fault supervisor
// assumes it is bound to wfs_supervisor and sees only its ports
`timescale 1ns/1ns
`default_nettype none

module wfs_supervisor_asserts #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_primary_overcurrent,
    input wire logic i_cap_overvoltage,
    input wire logic i_hsel,
    input wire logic [1:0] i_htrans,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic o_weld_enable,
    input wire logic o_buzzer,
    input wire logic o_fan_max,
    input wire logic [7:0] o_err_code,
    input wire logic o_err_valid,
    input wire logic o_irq
);
    // tick phase is unknown at the ports, so one tick of slack on each bound
    localparam int WIN_LO = 999 * TICK_CYCLES;
    localparam int WIN_HI = 1001 * TICK_CYCLES + 8;
    logic [31:0] up_cnt;
    logic [31:0] ov_cnt;
    logic shut;
    logic latched;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    ////////////////////////////////////////////////////////////////
    assign shut = o_err_valid && (o_err_code != 8'h14);
    // every code above 14 is a latched one
    assign latched = o_err_valid && (o_err_code > 8'h14 || o_err_code inside {8'h03, 8'h04});

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) up_cnt <= 32'h0;
        else if (up_cnt != 32'hFFFFFFFF) up_cnt <= up_cnt + 32'h1;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn || !i_cap_overvoltage) ov_cnt <= 32'h0;
        else if (ov_cnt != 32'hFFFFFFFF) ov_cnt <= ov_cnt + 32'h1;
    end

    ////////////////////////////////////////////////////////////////
    chk_bus_answer: assert property ((i_hsel && i_htrans[1] && o_hreadyout) |=> (o_hreadyout && !o_hresp))
        else $error("bus data phase not ready or not okay");
    chk_shut_weld: assert property (shut |-> !o_weld_enable)
        else $error("weld allowed under a shutdown code");
    chk_shut_buzz: assert property (shut |-> o_buzzer)
        else $error("buzzer silent under a shutdown code");
    chk_heat_fan: assert property ((o_err_valid && (o_err_code == 8'h01 || o_err_code == 8'h02)) |-> o_fan_max)
        else $error("fan not at max on heat code");
    chk_latch_hold: assert property (latched |=> latched)
        else $error("latched code went away without reset");
    chk_trip_fast: assert property ($rose(i_primary_overcurrent) |-> ##[1:6] (o_err_valid && !o_weld_enable))
        else $error("overcurrent did not trip in time");
    chk_check_window: assert property ((up_cnt < 32'(WIN_LO)) |-> !o_weld_enable)
        else $error("weld allowed during power-up check");
    chk_warn_weld: assert property ((up_cnt > 32'(WIN_HI) && o_err_valid && o_err_code == 8'h14) |-> o_weld_enable)
        else $error("weld blocked by warning alone");
    chk_qual_time: assert property ($rose(o_err_valid && o_err_code == 8'h11) |-> (ov_cnt >= 32'(WIN_LO)))
        else $error("overvoltage code shown too early");

    cover property (o_err_valid && o_err_code == 8'h01 && o_fan_max);
    cover property (o_err_code == 8'h14 && o_buzzer);
    cover property (o_err_code == 8'h99);
    cover property (o_irq);
endmodule

`default_nettype wire

// ---- verification/wfs_supervisor_tb.sv ----
// self-checking bench for the weld fault supervisor
// assumes the supervisor is the only slave, hready looped from hreadyout
`timescale 1ns/1ns
`default_nettype none
`include "wfs_consts.svh"

module wfs_supervisor_tb;
    // two clocks per tick keeps the 30 s recovery inside the run budget
    localparam int TC = 2;
    localparam int SC = 1000 * TC;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [16:0] f = 17'h0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic weld, buzz, fan, valid, irq;
    logic [7:0] code;
    logic [31:0] r, m;
    logic b;
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    int tg;
    int lat[10] = '{4, 5, 9, 10, 11, 12, 13, 14, 15, 16};

    wfs_supervisor #(.TICK_CYCLES(TC)) dut (.i_core_clk(clk), .i_resetn(rst_n),
        .i_switch_heatsink_sensor_above80(f[0]), .i_switch_heatsink_sensor_above70(f[1]),
        .i_diode_heatsink_sensor_above80(f[2]), .i_diode_heatsink_sensor_above70(f[3]),
        .i_primary_overcurrent(f[4]), .i_output_overvoltage(f[5]), .i_cap_overvoltage(f[6]),
        .i_cap_undervoltage(f[7]), .i_supply_low(f[8]), .i_supply_wrong(f[9]), .i_link_plug_absent(f[10]),
        .i_supply_unstable(f[11]), .i_precharge_fail(f[12]), .i_param_mem_fail(f[13]),
        .i_switch_heatsink_sensor_open(f[14]), .i_diode_heatsink_sensor_open(f[15]), .i_mains_lost(f[16]),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(),
        .o_weld_enable(weld), .o_buzzer(buzz), .o_fan_max(fan), .o_err_code(code), .o_err_valid(valid),
        .o_irq(irq));

    initial begin
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 95000) begin
            fails++;
            $display("MISMATCH at %0t: run timed out", $time);
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] outs();
        return {21'h0, weld, buzz, valid, code};
    endfunction

    // weld only after the power-up check and with no code; buzzer on any shutdown code
    function automatic logic [31:0] exp_out(input logic [7:0] c, input logic run);
        return {21'h0, run && c == 8'h0, c != 8'h0, c != 8'h0, c};
    endfunction

    function automatic logic [7:0] code_for(input int i);
        logic [7:0] t[17] = '{0, 0, 0, 0, 8'h03, 8'h04, 8'h11, 8'h12, 8'h14, 8'h81, 8'h82, 8'h83, 8'h85,
            8'h93, 8'h94, 8'h94, 8'h99};
        return t[i];
    endfunction

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        ahb(1'b0, a, 32'h0, d);
        chk(d, exp);
    endtask

    task automatic pwr();
        @(posedge clk);
        f <= 17'h0;
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h2A899FE4));
        pwr();
        rd_chk(`WFS_OFS_MASK, 32'h0);
        rd_chk(`WFS_OFS_STATUS, 32'h0);
        ahb(1'b1, `WFS_OFS_MASK, 32'h4, r);
        f[4] <= 1'b1;
        wt(10);
        chk({31'h0, irq}, 32'h1);
        rd_chk(`WFS_OFS_ACTIVE, 32'h4);
        rd_chk(`WFS_OFS_STATUS, 32'h4);
        ahb(1'b1, `WFS_OFS_STATUS, 32'h4, r);
        wt(2);
        chk({31'h0, irq}, 32'h0);
        m = $urandom;
        ahb(1'b1, `WFS_OFS_MASK, m, r);
        rd_chk(`WFS_OFS_MASK, m & 32'h3FFF);
        ahb(1'b1, 32'h10, m, r);
        rd_chk(32'h10, 32'h0);
        // every latched code, raised inside the check window and then released
        foreach (lat[i]) begin
            pwr();
            f[lat[i]] <= 1'b1;
            wt(10);
            chk(outs(), exp_out(code_for(lat[i]), 1'b0));
            f[lat[i]] <= 1'b0;
            wt(10);
            chk(outs(), exp_out(code_for(lat[i]), 1'b0));
        end
        pwr();
        wt(SC + 100);
        chk(outs(), exp_out(8'h0, 1'b1));
        rd_chk(`WFS_OFS_DISPLAY, 32'h1200);
        // a lapse before the second ends must restart the count
        f[6] <= 1'b1;
        wt(SC / 2 + $urandom % (SC / 3));
        f[6] <= 1'b0;
        wt(4);
        f[6] <= 1'b1;
        wt(SC - 100);
        chk(outs(), exp_out(8'h0, 1'b1));
        wt(200);
        chk(outs(), exp_out(8'h11, 1'b1));
        f[6] <= 1'b0;
        wt(10);
        chk(outs(), exp_out(8'h0, 1'b1));
        f[8] <= 1'b1;
        wt(SC + 100);
        chk({23'h0, weld, code}, 32'h114);
        tg = 0;
        b = buzz;
        repeat (2 * SC) begin
            wt(1);
            if (buzz !== b) tg++;
            b = buzz;
        end
        chk({31'h0, tg >= 2}, 32'h1);
        f[7] <= 1'b1;
        wt(SC + 100);
        chk(outs(), exp_out(8'h12, 1'b1));
        f[4] <= 1'b1;
        wt(10);
        chk(outs(), exp_out(8'h03, 1'b1));
        f[4] <= 1'b0;
        f[7] <= 1'b0;
        f[8] <= 1'b0;
        wt(10);
        chk(outs(), exp_out(8'h03, 1'b1));
        pwr();
        wt(SC + 100);
        // both heatsinks hot, then both cool: E01 shown first, both recover
        f[3:0] <= 4'hF;
        wt(SC + 100);
        chk(outs(), exp_out(8'h01, 1'b1));
        chk({31'h0, fan}, 32'h1);
        rd_chk(`WFS_OFS_ACTIVE, 32'h3);
        f[3:0] <= 4'h0;
        wt(29 * SC);
        chk(outs(), exp_out(8'h01, 1'b1));
        rd_chk(`WFS_OFS_ACTIVE, 32'h3);
        wt(SC + 100);
        chk(outs(), exp_out(8'h0, 1'b1));
        f[2] <= 1'b1;
        f[3] <= 1'b1;
        wt(SC + 100);
        chk(outs(), exp_out(8'h02, 1'b1));
        chk({31'h0, fan}, 32'h1);
        report_and_stop();
    end
endmodule

bind wfs_supervisor wfs_supervisor_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.i_core_clk(i_core_clk),
    .i_resetn(i_resetn), .i_primary_overcurrent(i_primary_overcurrent), .i_cap_overvoltage(i_cap_overvoltage),
    .i_hsel(i_hsel), .i_htrans(i_htrans), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_weld_enable(o_weld_enable), .o_buzzer(o_buzzer), .o_fan_max(o_fan_max), .o_err_code(o_err_code),
    .o_err_valid(o_err_valid), .o_irq(o_irq));

`default_nettype wire
